// [verilog/itp_consts.svh]
// Purpose: named constants of the instruction trace port
// Assumes: included by bare name wherever a constant is needed
// Notes:   encodings and field sizes only; types live in itp_pkg
`ifndef ITP_CONSTS_SVH
`define ITP_CONSTS_SVH

// widths
`define ITP_ADDR_W      32
`define ITP_CNT_W       16
`define ITP_SEL_W       3
`define ITP_CFG_W       85
`define ITP_SYNC_W      5

// bit positions inside the synchroniser vector
`define ITP_SB_TCLK     0
`define ITP_SB_EXT      1
`define ITP_SB_TCK      2
`define ITP_SB_TDI      3
`define ITP_SB_UPD      4

// execution stage status codes
`define ITP_STAT_EXEC   3'h0
`define ITP_STAT_NOEXEC 3'h1
`define ITP_STAT_WAIT   3'h2
`define ITP_STAT_BRANCH 3'h4
`define ITP_STAT_TRIG   3'h6
`define ITP_STAT_OFF    3'h7

// packet serialiser and trigger select
`define ITP_NIB_IDLE    4'h0
`define ITP_NIB_FIRST   3'h0
`define ITP_NIB_LAST    3'h7
`define ITP_NIB_MARKED  3'h2
`define ITP_SEL_NONE    3'h0

// reset values
`define ITP_CNT_RST     16'h0000
`define ITP_ADDR_RST    32'h0000_0000

`endif

// [verilog/itp_pkg.sv]
// Purpose: shared types of the instruction trace port
// Assumes: itp_consts.svh gives the widths
// Notes:   configuration image is loaded whole from the scan chain
`include "itp_consts.svh"
package itp_pkg;

  typedef struct packed {
    logic [`ITP_CNT_W-1:0]  cnt_reload;
    logic [`ITP_ADDR_W-1:0] addr_hi;
    logic [`ITP_ADDR_W-1:0] addr_lo;
    logic [`ITP_SEL_W-1:0]  trig_sel;
    logic                   half_rate;
    logic                   enable;
  } itp_cfg_t;

  typedef enum logic [0:0] {
    ITP_SER_IDLE,
    ITP_SER_SEND
  } itp_ser_state_t;

endpackage

// [verilog/itp_cmp_if.sv]
// Purpose: carries one address comparator pair's settings and result
// Assumes: driven by itp_top, served by itp_addr_cmp
// Notes:   match is registered inside the comparator
`timescale 1ns/1ps
`include "itp_consts.svh"
interface itp_cmp_if;
  logic [`ITP_ADDR_W-1:0] lo;
  logic [`ITP_ADDR_W-1:0] hi;
  logic [`ITP_ADDR_W-1:0] pc;
  logic                   valid;
  logic                   match;

  modport cmp (
    input  lo,
    input  hi,
    input  pc,
    input  valid,
    output match
  );

  modport top (
    output lo,
    output hi,
    output pc,
    output valid,
    input  match
  );
endinterface

// [verilog/itp_sync.sv]
// Purpose: two-flop synchroniser for a vector of independent levels
// Assumes: each bit is a level from outside the ref_clk domain
// Notes:   the first stage feeds only the second stage
`timescale 1ns/1ps
module itp_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = din;
    sync_d = meta_q;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign dout = sync_q;
endmodule

// [verilog/itp_addr_cmp.sv]
// Purpose: one address comparator pair, inclusive range on the fetch address
// Assumes: pc and valid come from the core on ref_clk
// Notes:   result is one cycle behind the instruction it matched
`timescale 1ns/1ps
`include "itp_consts.svh"
module itp_addr_cmp (
  input  wire logic ref_clk,
  input  wire logic rst,
  itp_cmp_if.cmp    cmp
);
  logic match_q;
  logic match_d;

  always_comb begin
    match_d = cmp.valid && (cmp.pc >= cmp.lo) && (cmp.pc <= cmp.hi);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      match_q <= 1'b0;
    end else begin
      match_q <= match_d;
    end
  end

  assign cmp.match = match_q;
endmodule

// [verilog/itp_top.sv]
// Purpose: instruction trace port; compresses core execution into a
//          per-cycle status plus branch-target packets on a nibble bus
// Assumes: core signals are on ref_clk; trace clock, trigger and the
//          configuration scan pins come from outside and are synchronised
// Notes:   while enabled, status, marker and nibble change a few ref_clk cycles after the trace clock edge
`timescale 1ns/1ps
`include "itp_consts.svh"

// Contract
// R01 - each 8-bit packet goes out low nibble first, high nibble on the next trace cycle.
// R02 - the branch packet marker is high only for the first packet of a branch address.
// R03 - status, marker and nibble bus change relative to the trace clock rising edge.
// R04 - a three-bit execution stage status is presented every trace cycle.
// R05 - the trace clock is made outside this unit from the system clock.
// R06 - a half-rate mode updates data on both trace clock edges.
// R07 - trace outputs lag the trace clock edge by a phase for hold margin.
// R08 - only branch targets are sent as packets, beside the per-cycle status.
// R09 - exactly one address comparator pair serves as a trigger resource.
// R10 - there are no data comparators; only instruction flow is traced.
// R11 - one external trigger input serves as a trigger resource.
// R12 - trace generation is gated by the selected trigger resources.
// R13 - all configuration is written by the debugger over the scan port.
// R14 - execution is observed from the core interface, not the system bus.
// R15 - the board selects trace pin function at reset by pulling the marker pin low; here branch_packet_marker is an output only and is never sampled.
// R16 - when disabled or after reset the outputs show a constant idle value.
module itp_top (
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic                   trace_port_clock,
  input  wire logic                   external_trigger_in,
  input  wire logic                   cfg_tck,
  input  wire logic                   cfg_tdi,
  input  wire logic                   cfg_update,
  input  wire logic                   core_instr_valid,
  input  wire logic                   core_instr_exec,
  input  wire logic                   core_branch,
  input  wire logic [`ITP_ADDR_W-1:0] core_pc,
  input  wire logic [`ITP_ADDR_W-1:0] core_branch_target,
  output logic      [2:0]             exec_stage_status,
  output logic                        branch_packet_marker,
  output logic      [3:0]             trace_nibble_bus,
  output logic                        buffer_nearly_full_flag
);

  // synchronisers and edge detection
  logic [`ITP_SYNC_W-1:0] pins_raw;
  logic [`ITP_SYNC_W-1:0] pins_s;
  logic [`ITP_SYNC_W-1:0] pins_prev_q;
  logic [`ITP_SYNC_W-1:0] pins_prev_d;

  assign pins_raw = {cfg_update, cfg_tdi, cfg_tck, external_trigger_in, trace_port_clock};

  // R05 trace clock sampled
  itp_sync #(
    .W (`ITP_SYNC_W)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     (pins_raw),
    .dout    (pins_s)
  );

  logic tclk_rise;
  logic tclk_fall;
  logic tck_rise;
  logic upd_rise;

  always_comb begin
    pins_prev_d = pins_s;
    tclk_rise   = pins_s[`ITP_SB_TCLK] & ~pins_prev_q[`ITP_SB_TCLK];
    tclk_fall   = ~pins_s[`ITP_SB_TCLK] & pins_prev_q[`ITP_SB_TCLK];
    tck_rise    = pins_s[`ITP_SB_TCK] & ~pins_prev_q[`ITP_SB_TCK];
    upd_rise    = pins_s[`ITP_SB_UPD] & ~pins_prev_q[`ITP_SB_UPD];
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pins_prev_q <= '0;
    end else begin
      pins_prev_q <= pins_prev_d;
    end
  end

  // configuration scan chain and image
  logic [`ITP_CFG_W-1:0] shift_q;
  logic [`ITP_CFG_W-1:0] shift_d;
  itp_pkg::itp_cfg_t     cfg_q;
  itp_pkg::itp_cfg_t     cfg_d;

  always_comb begin
    shift_d = shift_q;
    cfg_d   = cfg_q;
    // R13 scan shift
    if (tck_rise) begin
      shift_d = {pins_s[`ITP_SB_TDI], shift_q[`ITP_CFG_W-1:1]};
    end
    // R13 image update
    if (upd_rise) begin
      cfg_d = itp_pkg::itp_cfg_t'(shift_q);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shift_q <= '0;
      cfg_q   <= '0;
    end else begin
      shift_q <= shift_d;
      cfg_q   <= cfg_d;
    end
  end

  // trigger resources: one comparator pair, external input, counter
  itp_cmp_if cmp_bus ();

  // R14 core interface tap
  assign cmp_bus.lo    = cfg_q.addr_lo;
  assign cmp_bus.hi    = cfg_q.addr_hi;
  assign cmp_bus.pc    = core_pc;
  assign cmp_bus.valid = core_instr_valid;

  // R09 single comparator pair
  itp_addr_cmp u_cmp (
    .ref_clk (ref_clk),
    .rst     (rst),
    .cmp     (cmp_bus)
  );

  logic [`ITP_CNT_W-1:0] cnt_q;
  logic [`ITP_CNT_W-1:0] cnt_d;
  logic                  on_q;
  logic                  on_d;
  logic [`ITP_SEL_W-1:0] res_vec;
  logic                  trig_ev;

  always_comb begin
    cnt_d = cnt_q;
    if (upd_rise) begin
      cnt_d = cfg_d.cnt_reload;
    end else if (core_instr_valid && (cnt_q != `ITP_CNT_RST)) begin
      cnt_d = cnt_q - 1'b1;
    end
    // R11 external trigger resource
    res_vec = {(cnt_q == `ITP_CNT_RST), pins_s[`ITP_SB_EXT], cmp_bus.match};
    // R12 resource gating
    if (cfg_q.trig_sel == `ITP_SEL_NONE) begin
      on_d = cfg_q.enable;
    end else begin
      on_d = cfg_q.enable && (|(cfg_q.trig_sel & res_vec));
    end
    trig_ev = on_d & ~on_q & (cfg_q.trig_sel != `ITP_SEL_NONE);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_q <= `ITP_CNT_RST;
      on_q  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      on_q  <= on_d;
    end
  end

  // trace cycle tick and per-cycle status accumulation
  logic tick;
  logic acc_exec_q;
  logic acc_exec_d;
  logic acc_noex_q;
  logic acc_noex_d;
  logic acc_trig_q;
  logic acc_trig_d;
  logic [2:0] stat_now;

  always_comb begin
    // R03 rising edge starts a trace cycle
    // R06 half-rate adds the falling edge
    tick = cfg_q.enable & (tclk_rise | (cfg_q.half_rate & tclk_fall));
    // R10 only instruction flow is observed, no data values
    // events that land on the tick cycle go into the next trace cycle
    acc_exec_d = ((tick ? 1'b0 : acc_exec_q) | (on_d & core_instr_valid & core_instr_exec))
                 & cfg_q.enable;
    acc_noex_d = ((tick ? 1'b0 : acc_noex_q) | (on_d & core_instr_valid & ~core_instr_exec))
                 & cfg_q.enable;
    acc_trig_d = ((tick ? 1'b0 : acc_trig_q) | trig_ev) & cfg_q.enable;
    // R04 status priority
    if (acc_trig_q) begin
      stat_now = `ITP_STAT_TRIG;
    end else if (acc_exec_q) begin
      stat_now = `ITP_STAT_EXEC;
    end else if (acc_noex_q) begin
      stat_now = `ITP_STAT_NOEXEC;
    end else begin
      stat_now = `ITP_STAT_WAIT;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      acc_exec_q <= 1'b0;
      acc_noex_q <= 1'b0;
      acc_trig_q <= 1'b0;
    end else begin
      acc_exec_q <= acc_exec_d;
      acc_noex_q <= acc_noex_d;
      acc_trig_q <= acc_trig_d;
    end
  end

  // branch packet serialiser and output registers
  itp_pkg::itp_ser_state_t ser_q;
  itp_pkg::itp_ser_state_t ser_d;
  logic [`ITP_ADDR_W-1:0]  addr_q;
  logic [`ITP_ADDR_W-1:0]  addr_d;
  logic [`ITP_ADDR_W-1:0]  pend_q;
  logic [`ITP_ADDR_W-1:0]  pend_d;
  logic                    pend_v_q;
  logic                    pend_v_d;
  logic [2:0]              nib_q;
  logic [2:0]              nib_d;
  logic [2:0]              stat_q;
  logic [2:0]              stat_d;
  logic                    mark_q;
  logic                    mark_d;
  logic [3:0]              nout_q;
  logic [3:0]              nout_d;
  logic                    full_q;
  logic                    full_d;

  always_comb begin
    ser_d    = ser_q;
    addr_d   = addr_q;
    pend_d   = pend_q;
    pend_v_d = pend_v_q;
    nib_d    = nib_q;
    stat_d   = stat_q;
    mark_d   = mark_q;
    nout_d   = nout_q;
    // R07 updates land after the synchroniser delay, past the clock edge
    if (tick) begin
      stat_d = stat_now;
      mark_d = 1'b0;
      nout_d = `ITP_NIB_IDLE;
      unique case (ser_q)
        itp_pkg::ITP_SER_IDLE: begin
        end
        itp_pkg::ITP_SER_SEND: begin
          // R01 low nibble first
          nout_d = addr_q[{nib_q, 2'b00} +: 4];
          // R02 marker on first packet
          mark_d = (nib_q < `ITP_NIB_MARKED);
          // R08 branch status opens each packet group unless a pending trigger status takes that first nibble's trace cycle
          if ((nib_q == `ITP_NIB_FIRST) && !acc_trig_q) begin
            stat_d = `ITP_STAT_BRANCH;
          end
          nib_d  = nib_q + 1'b1;
          if (nib_q == `ITP_NIB_LAST) begin
            ser_d = itp_pkg::ITP_SER_IDLE;
          end
        end
      endcase
    end
    // next pending target starts once the previous one is fully out
    if ((ser_d == itp_pkg::ITP_SER_IDLE) && pend_v_q) begin
      ser_d    = itp_pkg::ITP_SER_SEND;
      addr_d   = pend_q;
      nib_d    = `ITP_NIB_FIRST;
      pend_v_d = 1'b0;
    end
    // R08 only branch targets become packets
    if (on_d && core_branch) begin
      pend_d   = core_branch_target;
      pend_v_d = 1'b1;
    end
    full_d = pend_v_d & (ser_d == itp_pkg::ITP_SER_SEND);
    // R16 idle outputs while disabled
    if (!cfg_q.enable) begin
      ser_d    = itp_pkg::ITP_SER_IDLE;
      pend_v_d = 1'b0;
      nib_d    = `ITP_NIB_FIRST;
      stat_d   = `ITP_STAT_OFF;
      mark_d   = 1'b0;
      nout_d   = `ITP_NIB_IDLE;
      full_d   = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      // R16 idle after reset
      ser_q    <= itp_pkg::ITP_SER_IDLE;
      addr_q   <= `ITP_ADDR_RST;
      pend_q   <= `ITP_ADDR_RST;
      pend_v_q <= 1'b0;
      nib_q    <= `ITP_NIB_FIRST;
      stat_q   <= `ITP_STAT_OFF;
      mark_q   <= 1'b0;
      nout_q   <= `ITP_NIB_IDLE;
      full_q   <= 1'b0;
    end else begin
      ser_q    <= ser_d;
      addr_q   <= addr_d;
      pend_q   <= pend_d;
      pend_v_q <= pend_v_d;
      nib_q    <= nib_d;
      stat_q   <= stat_d;
      mark_q   <= mark_d;
      nout_q   <= nout_d;
      full_q   <= full_d;
    end
  end

  assign exec_stage_status       = stat_q;
  assign branch_packet_marker    = mark_q;
  assign trace_nibble_bus        = nout_q;
  assign buffer_nearly_full_flag = full_q;

endmodule

// [verif/itp_checker.sv]
// Purpose: port checker for itp_top
// Assumes: the trace clock pin changes just after ref_clk rising edges
// Notes:   bound to every itp_top instance
`timescale 1ns/1ps
module itp_checker (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       trace_port_clock,
  input wire logic       core_branch,
  input wire logic [2:0] exec_stage_status,
  input wire logic       branch_packet_marker,
  input wire logic [3:0] trace_nibble_bus,
  input wire logic       buffer_nearly_full_flag
);
  logic       tclk_q;
  logic [7:0] since_q;
  logic [7:0] br_q;
  logic [7:0] mark_q;
  // cycles since trace clock edge, since branch, and of marker high
  always_ff @(posedge ref_clk) begin
    tclk_q  <= trace_port_clock;
    since_q <= (trace_port_clock != tclk_q) ? 8'h00 : since_q + {7'h00, since_q != 8'hFF};
    br_q    <= (rst || core_branch) ? {8{rst}} : br_q + {7'h00, br_q != 8'hFF};
    mark_q  <= !branch_packet_marker ? 8'h00 : mark_q + {7'h00, mark_q != 8'hFF};
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_RST_IDLE: assert property (
    $fell(rst) |-> exec_stage_status == 3'h7 && !branch_packet_marker
      && trace_nibble_bus == 4'h0 && !buffer_nearly_full_flag)
    else $error("outputs not idle after reset");
  AST_OFF_QUIET: assert property (
    exec_stage_status == 3'h7 |-> !branch_packet_marker && trace_nibble_bus == 4'h0)
    else $error("packet output while trace is off");
  AST_NIB_PHASE: assert property (
    ($changed(trace_nibble_bus) || $changed(branch_packet_marker))
      && exec_stage_status != 3'h7 |-> since_q != 8'h00)
    else $error("packet output changed with the trace clock edge");
  AST_STAT_PHASE: assert property (
    $changed(exec_stage_status) && exec_stage_status != 3'h7
      && $past(exec_stage_status) != 3'h7 |-> since_q != 8'h00)
    else $error("status changed with the trace clock edge");
  AST_MARK_BRANCH: assert property (
    $rose(branch_packet_marker) |-> br_q < 8'h64)
    else $error("packet without a recent branch");
  AST_MARK_STAT: assert property (
    $rose(branch_packet_marker) |-> exec_stage_status inside {3'h4, 3'h6})
    else $error("first packet without branch status");
  AST_MARK_LONG: assert property (
    branch_packet_marker |-> mark_q < 8'h14)
    else $error("marker held past the first packet");
  AST_MARK_SHORT: assert property (
    $fell(branch_packet_marker) |-> mark_q >= 8'h06)
    else $error("marker shorter than two nibbles");
endmodule

bind itp_top itp_checker i_chk (
  .ref_clk                (ref_clk),
  .rst                    (rst),
  .trace_port_clock       (trace_port_clock),
  .core_branch            (core_branch),
  .exec_stage_status      (exec_stage_status),
  .branch_packet_marker   (branch_packet_marker),
  .trace_nibble_bus       (trace_nibble_bus),
  .buffer_nearly_full_flag(buffer_nearly_full_flag)
);

// [verif/itp_trace_analyzer.sv]
// Purpose: trace port analyzer model; makes the trace clock and records
// Assumes: ref_clk is the system clock; 200 ns trace clock period
// Notes:   clock stands low while run is low; record is {status, marker, nibble}
`timescale 1ns/1ps
module itp_trace_analyzer (
  input  wire logic       ref_clk,
  input  wire logic       run,
  input  wire logic       both_edges,
  input  wire logic [2:0] exec_stage_status,
  input  wire logic       branch_packet_marker,
  input  wire logic [3:0] trace_nibble_bus,
  output logic            trace_port_clock
);
  logic [7:0] cap_q [0:511];
  logic [1:0] div_q;
  int         n;
  initial begin
    trace_port_clock = 1'b0;
    div_q = 2'h0;
    n = 0;
  end
  always @(posedge ref_clk) begin
    if (run || trace_port_clock) begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) begin
        trace_port_clock <= ~trace_port_clock;
        if (!trace_port_clock || both_edges) begin
          cap_q[n[8:0]] <= {exec_stage_status, branch_packet_marker, trace_nibble_bus};
          n <= n + 1;
        end
      end
    end
  end
endmodule

// [verif/itp_top_tb.sv]
// Purpose: self-checking bench for itp_top
// Assumes: analyzer model drives the trace clock
// Notes:   inputs change at the falling edge of ref_clk
`timescale 1ns/1ps
module itp_top_tb;
  logic        ref_clk;
  logic        rst;
  logic        tclk;
  logic        ext;
  logic        tck;
  logic        tdi;
  logic        upd;
  logic        iv;
  logic        ie;
  logic        br;
  logic        run;
  logic        half;
  logic [31:0] pc;
  logic [31:0] tgt;
  logic [2:0]  st;
  logic        mk;
  logic [3:0]  nb;
  logic        fl;
  int          fail_count;
  int          cmp_count;

  itp_top i_dut (
    .ref_clk(ref_clk), .rst(rst), .trace_port_clock(tclk), .external_trigger_in(ext),
    .cfg_tck(tck), .cfg_tdi(tdi), .cfg_update(upd), .core_instr_valid(iv),
    .core_instr_exec(ie), .core_branch(br), .core_pc(pc), .core_branch_target(tgt),
    .exec_stage_status(st), .branch_packet_marker(mk), .trace_nibble_bus(nb),
    .buffer_nearly_full_flag(fl)
  );
  itp_trace_analyzer i_ana (
    .ref_clk(ref_clk), .run(run), .both_edges(half), .exec_stage_status(st),
    .branch_packet_marker(mk), .trace_nibble_bus(nb), .trace_port_clock(tclk)
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic cycles(input int k);
    repeat (k) @(negedge ref_clk);
  endtask

  task automatic load(input logic en, input logic hf, input logic [2:0] sel,
                      input logic [31:0] lo, input logic [31:0] hi,
                      input logic [15:0] rl);
    itp_pkg::itp_cfg_t c;
    c = '{cnt_reload: rl, addr_hi: hi, addr_lo: lo, trig_sel: sel,
          half_rate: hf, enable: en};
    for (int i = 0; i < 85; i++) begin
      tdi = c[i];
      cycles(4);
      tck = 1'b1;
      cycles(4);
      tck = 1'b0;
    end
    upd = 1'b1;
    cycles(4);
    upd = 1'b0;
    cycles(4);
    half = hf;
  endtask

  task automatic wait_caps(input int k);
    int t;
    t = 0;
    while (i_ana.n < k) begin
      cycles(1);
      t++;
      if (t > 5000) begin
        fail_count++;
        stop_test();
      end
    end
  endtask

  function automatic int nstat(input int a, input int b, input logic [2:0] s);
    int c;
    c = 0;
    for (int i = a; i < b; i++) begin
      if (i_ana.cap_q[i] [7:5] === s) begin
        c++;
      end
    end
    return c;
  endfunction

  function automatic int fmark(input int a, input int b);
    for (int i = a; i < b; i++) begin
      if (i_ana.cap_q[i] [4] === 1'b1) begin
        return i;
      end
    end
    return -1;
  endfunction

  task automatic t_branch(input logic hf, input logic [31:0] t);
    int s;
    int m;
    load(1'b1, hf, 3'h0, 32'h0, 32'h0, 16'h0000);
    s = i_ana.n;
    run = 1'b1;
    iv = 1'b1;
    ie = 1'b1;
    cycles(40);
    iv = 1'b0;
    br = 1'b1;
    tgt = t;
    cycles(1);
    br = 1'b0;
    if (!hf) begin
      cycles(2);
      br = 1'b1;
      tgt = ~t;
      cycles(1);
      br = 1'b0;
      cycles(3);
      chk(fl, 1'b1);
    end
    wait_caps(s + 30);
    m = fmark(s, s + 30);
    chk(nstat(s, m, 3'h0) > 0, 1'b1);
    chk(i_ana.cap_q[m] [7:5], 3'h4);
    for (int k = 0; k < 8; k++) begin
      chk(i_ana.cap_q[m + k] [4:0], {k < 2, t[4*k+:4]});
    end
    run = 1'b0;
  endtask

  task automatic t_trigger();
    int s;
    load(1'b1, 1'b0, 3'h2, 32'h0, 32'h0, 16'h0000);
    s = i_ana.n;
    run = 1'b1;
    br = 1'b1;
    tgt = 32'h1234_5678;
    cycles(1);
    br = 1'b0;
    wait_caps(s + 14);
    chk(fmark(s, s + 14), 32'hFFFF_FFFF);
    s = i_ana.n;
    ext = 1'b1;
    wait_caps(s + 10);
    chk(nstat(s, s + 10, 3'h6), 32'h1);
    ext = 1'b0;
    run = 1'b0;
    load(1'b1, 1'b0, 3'h1, 32'h0000_0100, 32'h0000_01FF, 16'h0000);
    s = i_ana.n;
    run = 1'b1;
    cycles(16);
    pc = 32'h0000_0180;
    iv = 1'b1;
    cycles(1);
    iv = 1'b0;
    wait_caps(s + 8);
    chk(nstat(s, s + 8, 3'h6) > 0, 1'b1);
    run = 1'b0;
  endtask

  task automatic t_counter();
    int s;
    load(1'b1, 1'b0, 3'h4, 32'h0, 32'h0, 16'h0003);
    s = i_ana.n;
    run = 1'b1;
    iv = 1'b1;
    ie = 1'b0;
    cycles(3);
    iv = 1'b0;
    cycles(16);
    iv = 1'b1;
    cycles(24);
    iv = 1'b0;
    wait_caps(s + 10);
    chk(nstat(s, s + 10, 3'h6), 32'h1);
    chk(nstat(s, s + 10, 3'h1) > 0, 1'b1);
    run = 1'b0;
  endtask

  initial begin
    {rst, ext, tck, tdi, upd, iv, ie, br, run, half} = 10'h200;
    pc = 32'h0;
    tgt = 32'h0;
    fail_count = 0;
    cmp_count = 0;
    cycles(20);
    rst = 1'b0;
    cycles(4);
    chk({st, mk, nb, fl}, {3'h7, 1'b0, 4'h0, 1'b0});
    chk(mk, 1'b0);
    t_branch(1'b0, 32'h9A5C_3E71);
    t_branch(1'b1, 32'h4D2B_E816);
    t_trigger();
    t_counter();
    load(1'b0, 1'b0, 3'h0, 32'h0, 32'h0, 16'h0000);
    cycles(2);
    chk({st, mk, nb}, {3'h7, 1'b0, 4'h0});
    stop_test();
  end
endmodule
